// *** core/ird_consts.svh ***
// constants for the interrupt request decoder
`ifndef IRD_CONSTS_SVH
`define IRD_CONSTS_SVH

`define IRD_ADDR_ID_HI      31
`define IRD_ADDR_ID_LO      20
`define IRD_INTR_ID         12'hfee
`define IRD_ADDR_HND_HI     19
`define IRD_ADDR_HND_LO     5
`define IRD_ADDR_FMT_BIT    4
`define IRD_ADDR_SIV_BIT    3
`define IRD_ADDR_HND15_BIT  2
`define IRD_FAULT_RSVD      8'h20
`define IRD_FAULT_NONE      8'h00

`define IRD_REG_CTRL        12'h000
`define IRD_REG_STAT        12'h004
`define IRD_REG_COUNT       12'h008
`define IRD_REG_LAST        12'h00c
`define IRD_CTRL_REMAP_EN   0
`define IRD_STAT_REMAP_EN   0
`define IRD_STAT_BLOCKED    1
`define IRD_HIST_DEPTH      8
`define IRD_HIST_AW         3

`endif

// *** core/ird_decoder.sv ***
// upstream interrupt write decoder with apb control
// Behaviour
// - address bits 31:20 equal fee means interrupt
// - own fault and completion interrupts bypass remapping
// - address bit 4 clear means compatibility
// - address bit 4 set means remappable
// - primary index from bits 19:5 and 2
// - address bit 3 is secondary index valid
// - address bits 1:0 ignored
// - data 15:0 secondary index when valid
// - data 31:16 must be zero when valid
// - pcie msi origin id is requester id
// - bridged requests may alias to bridge bus
// - legacy bridge id used, no isolation
// - table index is primary plus optional secondary
// - nonzero reserved bits block, reason 20h
// - remapping disabled forces compatibility format
`include "ird_consts.svh"

module ird_decoder (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  // apb slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // upstream write
  input  wire logic                 wr_valid_i,
  input  wire logic                 wr_dword_i,
  input  wire logic                 wr_self_i,
  input  wire logic [31:0]          wr_addr_i,
  input  wire logic [31:0]          wr_data_i,
  input  wire logic [15:0]          wr_requester_id_i,
  // decoded request
  output logic                      irq_valid_o,
  output ird_pkg::ird_fmt_t         irq_fmt_o,
  output logic [15:0]               primary_index_o,
  output logic                      secondary_index_valid_o,
  output logic [15:0]               secondary_index_o,
  output logic [15:0]               table_index_o,
  output logic [15:0]               requester_origin_id_o,
  output logic                      blocked_o,
  output logic [7:0]                fault_reason_o,
  output logic                      mem_wr_valid_o,
  output logic                      remap_enabled_status_o
);
  logic                        remap_en_r;
  logic                        is_irq;
  logic                        fmt_remap;
  logic                        siv;
  logic [15:0]                 prim;
  logic [15:0]                 sec;
  logic                        rsvd_bad;
  ird_pkg::ird_fmt_t           fmt_nxt;
  logic [31:0]                 count_r;
  logic                        blocked_seen_r;
  logic [`IRD_HIST_AW-1:0]     hist_wp_r;
  logic [31:0]                 hist_rdata;
  logic                        apb_acc;

  // decode of the incoming write
  assign is_irq = wr_valid_i && wr_dword_i &&
    (wr_addr_i[`IRD_ADDR_ID_HI:`IRD_ADDR_ID_LO] == `IRD_INTR_ID);
  // disabled remapping forces compatibility
  assign fmt_remap = remap_en_r && wr_addr_i[`IRD_ADDR_FMT_BIT];
  assign siv = wr_addr_i[`IRD_ADDR_SIV_BIT];
  // bits 1:0 never read
  assign prim = {wr_addr_i[`IRD_ADDR_HND15_BIT],
                 wr_addr_i[`IRD_ADDR_HND_HI:`IRD_ADDR_HND_LO]};
  assign sec = siv ? wr_data_i[15:0] : 16'h0;
  assign rsvd_bad = siv && (wr_data_i[31:16] != 16'h0);

  always_comb begin
    if (wr_self_i) begin
      fmt_nxt = ird_pkg::IRD_FMT_SELF;
    end else if (fmt_remap) begin
      fmt_nxt = ird_pkg::IRD_FMT_REMAP;
    end else begin
      fmt_nxt = ird_pkg::IRD_FMT_COMPAT;
    end
  end

  // decoded request outputs
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_valid_o             <= 1'b0;
      irq_fmt_o               <= ird_pkg::IRD_FMT_NONE;
      primary_index_o         <= 16'h0;
      secondary_index_valid_o <= 1'b0;
      secondary_index_o       <= 16'h0;
      table_index_o           <= 16'h0;
      requester_origin_id_o   <= 16'h0;
      blocked_o               <= 1'b0;
      fault_reason_o          <= `IRD_FAULT_NONE;
    end else begin
      irq_valid_o <= is_irq;
      if (is_irq) begin
        irq_fmt_o <= fmt_nxt;
        // id passed through untouched, aliasing behind bridges kept
        requester_origin_id_o <= wr_requester_id_i;
        if (fmt_nxt == ird_pkg::IRD_FMT_REMAP) begin
          primary_index_o         <= prim;
          secondary_index_valid_o <= siv;
          secondary_index_o       <= sec;
          table_index_o           <= prim + sec;
          blocked_o               <= rsvd_bad;
          fault_reason_o          <= rsvd_bad ? `IRD_FAULT_RSVD
                                              : `IRD_FAULT_NONE;
        end else begin
          primary_index_o         <= 16'h0;
          secondary_index_valid_o <= 1'b0;
          secondary_index_o       <= 16'h0;
          table_index_o           <= 16'h0;
          blocked_o               <= 1'b0;
          fault_reason_o          <= `IRD_FAULT_NONE;
        end
      end
    end
  end

  // ordinary memory writes pass on
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_wr_valid_o <= 1'b0;
    end else begin
      mem_wr_valid_o <= wr_valid_i && !is_irq;
    end
  end

  // apb access phase; reads and writes both take one wait state
  assign apb_acc = psel_i && penable_i && pready_o;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      remap_en_r <= 1'b0;
    end else if (apb_acc && pwrite_i && paddr_i == `IRD_REG_CTRL) begin
      remap_en_r <= pwdata_i[`IRD_CTRL_REMAP_EN];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      remap_enabled_status_o <= 1'b0;
    end else begin
      remap_enabled_status_o <= remap_en_r;
    end
  end

  // request counter and sticky blocked flag, set wins over clear
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_r        <= 32'h0;
      blocked_seen_r <= 1'b0;
    end else begin
      if (is_irq) begin
        count_r <= count_r + 32'h1;
      end
      if (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP && rsvd_bad) begin
        blocked_seen_r <= 1'b1;
      end else if (apb_acc && pwrite_i && paddr_i == `IRD_REG_STAT &&
                   pwdata_i[`IRD_STAT_BLOCKED]) begin
        blocked_seen_r <= 1'b0;
      end
    end
  end

  // history of computed indices
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hist_wp_r <= '0;
    end else if (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP) begin
      hist_wp_r <= hist_wp_r + 3'h1;
    end
  end

  ird_hist_mem u_hist (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .we_i    (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP),
    .waddr_i (hist_wp_r),
    .wdata_i ({rsvd_bad, siv, 14'h0, prim + sec}),
    .raddr_i (hist_wp_r - 3'h1),
    .rdata_o (hist_rdata)
  );

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o  <= 1'b1;
      pslverr_o <= !(paddr_i == `IRD_REG_CTRL || paddr_i == `IRD_REG_STAT ||
                     paddr_i == `IRD_REG_COUNT || paddr_i == `IRD_REG_LAST);
      unique case (paddr_i)
        `IRD_REG_CTRL:  prdata_o <= {31'h0, remap_en_r};
        `IRD_REG_STAT:  prdata_o <= {30'h0, blocked_seen_r, remap_en_r};
        `IRD_REG_COUNT: prdata_o <= count_r;
        `IRD_REG_LAST:  prdata_o <= hist_rdata;
        default:        prdata_o <= 32'h0;
      endcase
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // checks
  property p_irq_strobe;
    @(posedge mclk_i) disable iff (!nrst_i)
      is_irq |=> irq_valid_o;
  endproperty
  a_irq_strobe: assert property (p_irq_strobe)
    else $error("strobe missing after interrupt write");

  property p_not_irq;
    @(posedge mclk_i) disable iff (!nrst_i)
      (wr_valid_i && wr_addr_i[31:20] != 12'hfee) |=> !irq_valid_o
        && mem_wr_valid_o;
  endproperty
  a_not_irq: assert property (p_not_irq)
    else $error("non interrupt write decoded as interrupt");

  property p_self;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && wr_self_i) |=> irq_fmt_o == ird_pkg::IRD_FMT_SELF;
  endproperty
  a_self: assert property (p_self)
    else $error("own interrupt was remapped");

  property p_compat;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && !wr_self_i && !wr_addr_i[4]) |=>
        irq_fmt_o == ird_pkg::IRD_FMT_COMPAT;
  endproperty
  a_compat: assert property (p_compat)
    else $error("bit 4 clear not compatibility");

  property p_disabled;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && !wr_self_i && !remap_en_r) |=>
        irq_fmt_o == ird_pkg::IRD_FMT_COMPAT;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("remappable format while disabled");

  property p_index;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP) |=>
        primary_index_o == {$past(wr_addr_i[2]), $past(wr_addr_i[19:5])}
        && table_index_o == primary_index_o + secondary_index_o;
  endproperty
  a_index: assert property (p_index)
    else $error("index assembly wrong");

  property p_sec;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP && !wr_addr_i[3]) |=>
        secondary_index_o == 16'h0 && !blocked_o;
  endproperty
  a_sec: assert property (p_sec)
    else $error("data used without valid flag");

  property p_block;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP && wr_addr_i[3]
        && wr_data_i[31:16] != 16'h0) |=>
        blocked_o && fault_reason_o == 8'h20 ##1 blocked_seen_r;
  endproperty
  a_block: assert property (p_block)
    else $error("reserved bits not blocked");

  property p_remap;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && !wr_self_i && remap_en_r && wr_addr_i[4]) |=>
        irq_fmt_o == ird_pkg::IRD_FMT_REMAP;
  endproperty
  a_remap: assert property (p_remap)
    else $error("bit 4 set not remappable");

  property p_siv;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP) |=>
        secondary_index_valid_o == $past(wr_addr_i[3]);
  endproperty
  a_siv: assert property (p_siv)
    else $error("valid flag not taken from bit 3");

  property p_subidx;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP && wr_addr_i[3]) |=>
        secondary_index_o == $past(wr_data_i[15:0]);
  endproperty
  a_subidx: assert property (p_subidx)
    else $error("secondary index not taken from data");

  property p_clean;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && fmt_nxt == ird_pkg::IRD_FMT_REMAP && wr_addr_i[3]
        && wr_data_i[31:16] == 16'h0) |=>
        !blocked_o && fault_reason_o == 8'h00;
  endproperty
  a_clean: assert property (p_clean)
    else $error("clean request blocked");

  property p_origin;
    @(posedge mclk_i) disable iff (!nrst_i)
      is_irq |=> requester_origin_id_o == $past(wr_requester_id_i);
  endproperty
  a_origin: assert property (p_origin)
    else $error("origin id not passed through");

  property p_pulse;
    @(posedge mclk_i) disable iff (!nrst_i)
      !is_irq |=> !irq_valid_o && $stable(table_index_o);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe or fields moved without request");

  property p_self_bypass;
    @(posedge mclk_i) disable iff (!nrst_i)
      (is_irq && wr_self_i) |=> table_index_o == 16'h0 && !blocked_o;
  endproperty
  a_self_bypass: assert property (p_self_bypass)
    else $error("own interrupt went through index logic");

  property p_mem;
    @(posedge mclk_i) disable iff (!nrst_i)
      is_irq |=> !mem_wr_valid_o;
  endproperty
  a_mem: assert property (p_mem)
    else $error("interrupt passed on as memory write");

  c_remap: cover property (@(posedge mclk_i)
    irq_valid_o && irq_fmt_o == ird_pkg::IRD_FMT_REMAP);
  c_blocked: cover property (@(posedge mclk_i) blocked_o && irq_valid_o);
  c_compat: cover property (@(posedge mclk_i)
    irq_valid_o && irq_fmt_o == ird_pkg::IRD_FMT_COMPAT);
  c_self: cover property (@(posedge mclk_i)
    irq_valid_o && irq_fmt_o == ird_pkg::IRD_FMT_SELF);
endmodule

// *** core/ird_hist_mem.sv ***
// small history memory of decoded table indices
`include "ird_consts.svh"

module ird_hist_mem (
  input  wire logic                      mclk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      we_i,
  input  wire logic [`IRD_HIST_AW-1:0]   waddr_i,
  input  wire logic [31:0]               wdata_i,
  input  wire logic [`IRD_HIST_AW-1:0]   raddr_i,
  output logic      [31:0]               rdata_o
);
  logic [31:0] mem_r [`IRD_HIST_DEPTH];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule

// *** core/ird_pkg.sv ***
// types for the interrupt request decoder
package ird_pkg;
  typedef enum logic [1:0] {
    IRD_FMT_NONE   = 2'h0,
    IRD_FMT_COMPAT = 2'h1,
    IRD_FMT_REMAP  = 2'h3,
    IRD_FMT_SELF   = 2'h2
  } ird_fmt_t;
endpackage

// *** tb/ird_decoder_bench.sv ***
// self-checking bench for the interrupt request decoder
module ird_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, wr_addr_i, wr_data_i, rd;
  logic        pready_o, pslverr_o, wr_valid_i, wr_dword_i, wr_self_i;
  logic [15:0] wr_requester_id_i, primary_index_o, secondary_index_o;
  logic [15:0] table_index_o, requester_origin_id_o;
  logic        irq_valid_o, secondary_index_valid_o, blocked_o, er;
  logic [7:0]  fault_reason_o;
  logic        mem_wr_valid_o, remap_enabled_status_o;
  logic        ctrl_on = 1'b0;
  int          err_count = 0;
  int          checks = 0;
  int          n_irq = 0;
  ird_pkg::ird_fmt_t irq_fmt_o;

  always #50 mclk_i = ~mclk_i;

  ird_root_port u_rp (
    .mclk_i(mclk_i),
    .wr_valid_o(wr_valid_i),
    .wr_dword_o(wr_dword_i),
    .wr_self_o(wr_self_i),
    .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i),
    .wr_requester_id_o(wr_requester_id_i)
  );

  ird_decoder u_dut (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .wr_valid_i(wr_valid_i),
    .wr_dword_i(wr_dword_i),
    .wr_self_i(wr_self_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .wr_requester_id_i(wr_requester_id_i),
    .irq_valid_o(irq_valid_o),
    .irq_fmt_o(irq_fmt_o),
    .primary_index_o(primary_index_o),
    .secondary_index_valid_o(secondary_index_valid_o),
    .secondary_index_o(secondary_index_o),
    .table_index_o(table_index_o),
    .requester_origin_id_o(requester_origin_id_o),
    .blocked_o(blocked_o),
    .fault_reason_o(fault_reason_o),
    .mem_wr_valid_o(mem_wr_valid_o),
    .remap_enabled_status_o(remap_enabled_status_o)
  );

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      test_done();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // one upstream write, outputs judged against the decode rules
  task automatic req(input logic [31:0] a, d, input logic [15:0] id,
                     input logic dw, sf);
    logic irq, rm, siv, blk;
    logic [15:0] pi, sub, ti;
    logic [1:0] f;
    irq = dw && a[31:20] == 12'hfee;
    rm = irq && !sf && ctrl_on && a[4];
    siv = rm && a[3];
    pi = rm ? {a[2], a[19:5]} : 16'h0;
    sub = siv ? d[15:0] : 16'h0;
    blk = siv && d[31:16] != 16'h0;
    ti = pi + sub;
    f = sf ? ird_pkg::IRD_FMT_SELF :
        rm ? ird_pkg::IRD_FMT_REMAP : ird_pkg::IRD_FMT_COMPAT;
    @(posedge mclk_i);
    u_rp.send(a, d, id, dw, sf, 1'b1);
    @(negedge mclk_i);
    chk("irq_valid", irq, irq_valid_o);
    chk("mem_wr", !irq, mem_wr_valid_o);
    if (irq) begin
      n_irq++;
      chk("fmt", f, irq_fmt_o);
      chk("primary", pi, primary_index_o);
      chk("siv", siv, secondary_index_valid_o);
      chk("secondary", sub, secondary_index_o);
      chk("table", ti, table_index_o);
      chk("origin", id, requester_origin_id_o);
      chk("blocked", blk, blocked_o);
      chk("reason", blk ? 8'h20 : 8'h0, fault_reason_o);
      @(negedge mclk_i);
      chk("pulse", 1'b0, irq_valid_o);
      chk("held", ti, table_index_o);
    end
  endtask

  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 1'b1, er);
    chk("unmapped_rd", 32'h0, rd);
  endtask

  task automatic t_disabled;
    req(32'hfeeabcd7, 32'h0, 16'h0100, 1'b1, 1'b0);
    req(32'hfee00038, 32'h5, 16'h0101, 1'b1, 1'b0);
  endtask

  task automatic t_enable;
    apb(1'b1, 12'h000, 32'h1);
    ctrl_on = 1'b1;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("status", 1'b1, remap_enabled_status_o);
  endtask

  task automatic t_remap;
    req(32'hfeeabcd7, 32'hffff1234, 16'h0200, 1'b1, 1'b0);
    req(32'hfeeffff4, 32'h0, 16'h0201, 1'b1, 1'b0);
    req(32'hfee00010, 32'h0, 16'h0300, 1'b1, 1'b0);
    req(32'hfee00038, 32'h5, 16'h0202, 1'b1, 1'b0);
    req(32'hfeeffffc, 32'h2, 16'h0203, 1'b1, 1'b0);
    req(32'hfee00038, 32'h00010003, 16'h0204, 1'b1, 1'b0);
    req(32'hfee00000, 32'h0, 16'h0205, 1'b1, 1'b0);
    req(32'hfee00038, 32'h0, 16'h0206, 1'b1, 1'b1);
    req(32'hfee00038, 32'h0, 16'h0207, 1'b0, 1'b0);
    req(32'hfed00038, 32'h0, 16'h0208, 1'b1, 1'b0);
  endtask

  task automatic t_b2b;
    @(posedge mclk_i);
    fork
      begin
        u_rp.send(32'hfee00030, 32'h0, 16'h0300, 1'b1, 1'b0, 1'b0);
        u_rp.send(32'hfee00050, 32'h0, 16'h0301, 1'b1, 1'b0, 1'b1);
      end
      begin
        repeat (2) @(negedge mclk_i);
        chk("b2b_first", 16'h1, primary_index_o);
        @(negedge mclk_i);
        chk("b2b_valid", 1'b1, irq_valid_o);
        chk("b2b_second", 16'h2, primary_index_o);
      end
    join
    n_irq += 2;
  endtask

  task automatic t_status;
    apb(1'b0, 12'h004, 32'h0);
    chk("stat", 32'h3, rd);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b0, 12'h004, 32'h0);
    chk("stat_clr", 32'h1, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("count", n_irq, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("last", 32'h2, rd);
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_disabled();
    t_enable();
    t_remap();
    t_b2b();
    t_status();
    test_done();
  end
endmodule

// *** tb/ird_root_port.sv ***
// root port model that delivers upstream writes
module ird_root_port (
  // clock
  input  wire logic        mclk_i,
  // upstream write
  output logic             wr_valid_o,
  output logic             wr_dword_o,
  output logic             wr_self_o,
  output logic [31:0]      wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic [15:0]      wr_requester_id_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    wr_valid_o = 1'b0;
    wr_dword_o = 1'b0;
    wr_self_o = 1'b0;
    wr_addr_o = 32'h0;
    wr_data_o = 32'h0;
    wr_requester_id_o = 16'h0;
  end

  // call just after an edge; rel=0 keeps valid up
  task automatic send(input logic [31:0] a, d, input logic [15:0] id,
                      input logic dw, sf, rel);
    wr_valid_o <= 1'b1;
    wr_dword_o <= dw;
    wr_self_o <= sf;
    wr_addr_o <= a;
    wr_data_o <= d;
    wr_requester_id_o <= id;
    @(posedge mclk_i);
    if (rel) begin
      wr_valid_o <= 1'b0;
      wr_dword_o <= ~dw;
      wr_self_o <= ~sf;
      wr_addr_o <= ~a;
      wr_data_o <= ~d;
      wr_requester_id_o <= ~id;
    end
  endtask
endmodule
